// ===== core/scm_pkg.sv
package scm_pkg;
	// Source select codes
	typedef enum logic [1:0] {
		SCM_SRC_RC = 2'h0,
		SCM_SRC_EXT = 2'h1,
		SCM_SRC_PLL = 2'h2
	} scm_src_t;

	// Switch sequencer states, one-hot
	typedef enum logic [3:0] {
		SCM_ST_RUN = 4'h1,
		SCM_ST_GATE = 4'h2,
		SCM_ST_WAIT = 4'h4,
		SCM_ST_OPEN = 4'h8
	} scm_state_t;

	// Prescaler settings for the three bus domains
	typedef struct packed {
		logic [3:0] sys_div;
		logic [2:0] hs_div;
		logic [2:0] ls_div;
	} scm_presc_t;

	// Per-domain clock enable pulses
	typedef struct packed {
		logic sys_en;
		logic hs_en;
		logic ls_en;
	} scm_ticks_t;

	localparam int unsigned SCM_CLK_HZ = 50000000;
	localparam int unsigned SCM_RC_HZ = 8000000;
	localparam int unsigned SCM_RC_PLL_MAX_HZ = 64000000;
	// Multiplier code n gives a ratio of n + 2, so the 64 MHz cap fits the 4-bit field
	localparam int unsigned SCM_PLL_MUL_BIAS = 2;
	localparam logic [3:0] SCM_RC_PLL_MAX_MUL = 4'(SCM_RC_PLL_MAX_HZ / (SCM_RC_HZ / 2) - SCM_PLL_MUL_BIAS);
	// Failure monitor: external clock must toggle within this window
	localparam int unsigned SCM_FAIL_TIME_NS = 2000;
	localparam int unsigned SCM_FAIL_CYC = (SCM_FAIL_TIME_NS * (SCM_CLK_HZ / 1000000)) / 1000;
	localparam logic [7:0] SCM_FAIL_CNT = 8'(SCM_FAIL_CYC);
	// Countdown loaded for each wait around a source change; the gated clock stays off 11 cycles in all
	localparam logic [3:0] SCM_GAP_CYC = 4'h4;
	localparam logic [7:0] SCM_CNT_ZERO = 8'h00;
	localparam logic [3:0] SCM_GAP_ZERO = 4'h0;
	localparam logic [7:0] SCM_DIV_ZERO = 8'h00;
	localparam logic [7:0] SCM_DIV_ONE = 8'h01;

	// Divide ratio is 2**code, held at 256 for codes 8 and up
	function automatic logic [7:0] scm_div_max(input logic [3:0] code);
		scm_div_max = 8'((9'h001 << code) - 9'h001);
	endfunction
endpackage

// ===== core/scm_clock_select_monitor.sv
`timescale 1ns/1ps
// Functional notes
// - Reset always selects internal fast RC as core clock source.
// - External fast oscillator selectable; supervised for failure while used.
// - External failure falls back to internal RC without software.
// - Failure raises interrupt request only when its enable is set.
// - PLL input path failure is also reported as interrupt.
// - Separate prescalers for system bus, high- and low-speed peripheral domains.
// - RC-referenced PLL limited to 64 MHz system clock.
// - Deep stop disables PLL, internal RC and external oscillator.
module scm_clock_select_monitor
	import scm_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire scm_pkg::scm_src_t src_req_in,
	input wire logic pll_ref_ext_in,
	input wire logic [3:0] pll_mul_in,
	input wire logic pll_en_in,
	input wire logic external_fast_osc_en_in,
	input wire logic monitor_en_in,
	input wire logic fail_irq_en_in,
	input wire logic pll_irq_en_in,
	input wire logic fail_clear_in,
	input wire logic deep_stop_in,
	input wire logic external_fast_osc_clk_in,
	input wire logic pll_lock_in,
	input wire scm_pkg::scm_presc_t presc_in,
	output logic internal_fast_rc_on_out,
	output logic external_fast_osc_on_out,
	output logic pll_on_out,
	output logic [3:0] pll_mul_out,
	output scm_pkg::scm_src_t src_sel_out,
	output logic core_clk_gate_out,
	output logic switching_out,
	output logic ext_fail_out,
	output logic irq_out,
	output logic usb_clock_ok_out,
	output scm_pkg::scm_ticks_t ticks_out
);
	import scm_pkg::*;

	scm_state_t state_q;
	scm_src_t src_q;
	scm_src_t target_q;
	logic [3:0] gap_q;
	logic [7:0] mon_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic fail_q;
	logic pll_fail_q;
	logic [7:0] sys_cnt_q;
	logic [7:0] hs_cnt_q;
	logic [7:0] ls_cnt_q;
	logic ext_edge;
	logic ext_in_use;
	logic fail_evt;
	logic pll_on_d;
	logic src_ok;

	assign ext_in_use = external_fast_osc_on_out && (src_q == SCM_SRC_EXT || (src_q == SCM_SRC_PLL && pll_ref_ext_in));
	assign ext_edge = ext_s2_q ^ ext_s3_q;
	// Monitor times out when no edge is seen for the failure window
	assign fail_evt = monitor_en_in && ext_in_use && (mon_q == SCM_FAIL_CNT);
	assign pll_on_d = pll_en_in && !deep_stop_in && !(pll_ref_ext_in && fail_q);
	// An EXT or PLL request is honoured only if its source is running and not failed; an RC request is always honoured
	always_comb
	begin
		unique case (src_req_in)
			SCM_SRC_EXT: src_ok = external_fast_osc_on_out && !fail_q;
			SCM_SRC_PLL: src_ok = pll_on_out && pll_lock_in && !(pll_ref_ext_in && fail_q);
			default: src_ok = 1'b1;
		endcase
	end

	// External clock sampling; only the second and third stages are compared
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end
		else
		begin
			ext_s1_q <= external_fast_osc_clk_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in || ext_edge || !ext_in_use || fail_evt)
			mon_q <= SCM_CNT_ZERO;
		else
			mon_q <= mon_q + SCM_DIV_ONE;
	end

	// Sticky failure flags; a new failure wins over a clear in the same cycle
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			fail_q <= 1'b0;
			pll_fail_q <= 1'b0;
		end
		else
		begin
			fail_q <= fail_evt || (fail_q && !fail_clear_in);
			pll_fail_q <= (fail_evt && pll_ref_ext_in && pll_en_in) || (pll_fail_q && !fail_clear_in);
		end
	end

	assign irq_out = (fail_q && fail_irq_en_in) || (pll_fail_q && pll_irq_en_in);
	assign ext_fail_out = fail_q;

	// Oscillator enables; deep stop turns off all fast sources
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			internal_fast_rc_on_out <= 1'b1;
			external_fast_osc_on_out <= 1'b0;
			pll_on_out <= 1'b0;
			pll_mul_out <= SCM_GAP_ZERO;
		end
		else
		begin
			internal_fast_rc_on_out <= !deep_stop_in;
			external_fast_osc_on_out <= external_fast_osc_en_in && !deep_stop_in;
			pll_on_out <= pll_on_d;
			// Cap the multiplier when the RC feeds the PLL
			if (!pll_ref_ext_in && pll_mul_in > SCM_RC_PLL_MAX_MUL)
				pll_mul_out <= SCM_RC_PLL_MAX_MUL;
			else
				pll_mul_out <= pll_mul_in;
		end
	end

	// Switch sequencer: gate off, wait, change mux, wait, gate on
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			state_q <= SCM_ST_RUN;
			src_q <= SCM_SRC_RC;
			target_q <= SCM_SRC_RC;
			gap_q <= SCM_GAP_ZERO;
		end
		else
		begin
			unique case (state_q)
				SCM_ST_RUN:
				begin
					if (fail_evt && src_q != SCM_SRC_RC)
					begin
						target_q <= SCM_SRC_RC;
						state_q <= SCM_ST_GATE;
					end
					else if (src_req_in != src_q && src_ok)
					begin
						target_q <= src_req_in;
						state_q <= SCM_ST_GATE;
					end
				end
				SCM_ST_GATE:
				begin
					gap_q <= SCM_GAP_CYC;
					state_q <= SCM_ST_WAIT;
				end
				SCM_ST_WAIT:
				begin
					if (gap_q == SCM_GAP_ZERO)
					begin
						src_q <= target_q;
						gap_q <= SCM_GAP_CYC;
						state_q <= SCM_ST_OPEN;
					end
					else
						gap_q <= gap_q - 4'h1;
				end
				SCM_ST_OPEN:
				begin
					if (gap_q == SCM_GAP_ZERO)
						state_q <= SCM_ST_RUN;
					else
						gap_q <= gap_q - 4'h1;
				end
				default:
					state_q <= SCM_ST_RUN;
			endcase
		end
	end

	// Mux changes only while the core clock gate is closed
	assign core_clk_gate_out = (state_q == SCM_ST_RUN) && !deep_stop_in;
	assign switching_out = state_q != SCM_ST_RUN;
	assign src_sel_out = src_q;
	// Status only; the 48 MHz ratio is software's choice
	assign usb_clock_ok_out = external_fast_osc_on_out && pll_on_out && pll_ref_ext_in && pll_lock_in;

	// Cascaded prescalers; limits of 72 and 36 MHz are left to software
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			sys_cnt_q <= SCM_DIV_ZERO;
			hs_cnt_q <= SCM_DIV_ZERO;
			ls_cnt_q <= SCM_DIV_ZERO;
			ticks_out <= '0;
		end
		else
		begin
			ticks_out.sys_en <= (sys_cnt_q == SCM_DIV_ZERO) && core_clk_gate_out;
			ticks_out.hs_en <= 1'b0;
			ticks_out.ls_en <= 1'b0;
			if (!core_clk_gate_out)
				sys_cnt_q <= sys_cnt_q;
			else if (sys_cnt_q >= scm_div_max(presc_in.sys_div))
				sys_cnt_q <= SCM_DIV_ZERO;
			else
				sys_cnt_q <= sys_cnt_q + SCM_DIV_ONE;
			if (core_clk_gate_out && sys_cnt_q == SCM_DIV_ZERO)
			begin
				ticks_out.hs_en <= hs_cnt_q == SCM_DIV_ZERO;
				ticks_out.ls_en <= ls_cnt_q == SCM_DIV_ZERO;
				hs_cnt_q <= (hs_cnt_q >= scm_div_max({1'b0, presc_in.hs_div})) ? SCM_DIV_ZERO : hs_cnt_q + SCM_DIV_ONE;
				ls_cnt_q <= (ls_cnt_q >= scm_div_max({1'b0, presc_in.ls_div})) ? SCM_DIV_ZERO : ls_cnt_q + SCM_DIV_ONE;
			end
		end
	end
endmodule

// ===== bench/scm_osc_model.sv
`timescale 1ns/1ps
module scm_osc_model(
	input wire logic run_in,
	output logic osc_out
);
	// About 10.6 MHz, phase unrelated to the reference; held still it models a dead crystal
	initial osc_out = 1'b0;
	always #47 if (run_in) osc_out = ~osc_out;
endmodule

// ===== bench/scm_clock_select_monitor_chk.sv
`timescale 1ns/1ps
module scm_clock_select_monitor_chk
	import scm_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic monitor_en_in,
	input wire logic fail_irq_en_in,
	input wire logic pll_irq_en_in,
	input wire logic deep_stop_in,
	input wire logic external_fast_osc_clk_in,
	input wire logic internal_fast_rc_on_out,
	input wire logic external_fast_osc_on_out,
	input wire logic pll_on_out,
	input wire scm_pkg::scm_src_t src_sel_out,
	input wire logic core_clk_gate_out,
	input wire logic switching_out,
	input wire logic ext_fail_out,
	input wire logic irq_out,
	input wire scm_pkg::scm_ticks_t ticks_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	logic osc_q;
	logic [7:0] idle_q;
	// Saturating count of cycles since the external clock last moved
	always_ff @(posedge ref_clk_in)
	begin
		osc_q <= external_fast_osc_clk_in;
		if (rst_in || osc_q != external_fast_osc_clk_in)
			idle_q <= 8'h00;
		else if (idle_q != 8'hff)
			idle_q <= idle_q + 8'h01;
	end
	sequence gate_shut;
		!core_clk_gate_out [*8];
	endsequence
	rst_rc_a: assert property ($fell(rst_in) |-> src_sel_out == SCM_SRC_RC && internal_fast_rc_on_out)
		else $error("source after reset is not the RC");
	gate_chg_a: assert property ($changed(src_sel_out) |-> !core_clk_gate_out)
		else $error("source changed with the gate open");
	gap_hold_a: assert property ($rose(switching_out) |-> gate_shut ##1 !core_clk_gate_out [*3] ##1 core_clk_gate_out)
		else $error("gate gap around a switch is wrong");
	fallback_a: assert property ($rose(ext_fail_out) |-> ##[1:14] src_sel_out == SCM_SRC_RC)
		else $error("no fallback to the RC after failure");
	fail_seen_a: assert property (monitor_en_in && src_sel_out == SCM_SRC_EXT && !switching_out |-> idle_q < 8'h6e)
		else $error("dead external clock left in use");
	irq_set_a: assert property (ext_fail_out && fail_irq_en_in |-> irq_out)
		else $error("enabled failure raised no request");
	irq_mask_a: assert property (irq_out |-> (ext_fail_out && fail_irq_en_in) || pll_irq_en_in)
		else $error("request raised while masked");
	stop_osc_a: assert property (deep_stop_in |=> !pll_on_out && !external_fast_osc_on_out && !internal_fast_rc_on_out)
		else $error("oscillator left on in deep stop");
	tick_casc_a: assert property (ticks_out.hs_en || ticks_out.ls_en |-> ticks_out.sys_en)
		else $error("peripheral tick without a bus tick");
endmodule

// ===== bench/system_clock_select_monitor_tb_top.sv
`timescale 1ns/1ps
module system_clock_select_monitor_tb_top;
	import scm_pkg::*;
	logic ref_clk_in = 1'b0, rst_in = 1'b1, pll_ref_ext_in = 1'b0, pll_en_in = 1'b0, pll_lock_in = 1'b1;
	logic external_fast_osc_en_in = 1'b0, monitor_en_in = 1'b1, fail_irq_en_in = 1'b1, pll_irq_en_in = 1'b0;
	logic fail_clear_in = 1'b0, deep_stop_in = 1'b0, osc_run = 1'b1, external_fast_osc_clk_in;
	logic [3:0] pll_mul_in = 4'h0;
	scm_src_t src_req_in = SCM_SRC_RC;
	scm_presc_t presc_in = '0;
	logic internal_fast_rc_on_out, external_fast_osc_on_out, pll_on_out, core_clk_gate_out, switching_out;
	logic ext_fail_out, irq_out, usb_clock_ok_out;
	logic [3:0] pll_mul_out;
	scm_src_t src_sel_out, seen = SCM_SRC_RC;
	scm_ticks_t ticks_out;
	scm_src_t exp_q[$];
	int err_total = 0, total_checks = 0, seed = 47, n_sys, n_hs, n_ls;
	always #10 ref_clk_in = ~ref_clk_in;
	scm_clock_select_monitor dut(.*);
	scm_osc_model osc(.run_in(osc_run), .osc_out(external_fast_osc_clk_in));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask
	// Bounded wait: 0 for the switch to finish, 1 for the failure flag
	task automatic wait_for(input int which);
		int n;
		n = 0;
		while ((which ? ext_fail_out : !switching_out) !== 1'b1 && n < 300)
		begin
			cyc(1);
			n++;
		end
		if (n == 300)
		begin
			err_total++;
			complete_run();
		end
	endtask
	// Every source change seen is matched against the oldest noted one
	always @(negedge ref_clk_in)
		if (!rst_in && src_sel_out !== seen)
		begin
			seen = src_sel_out;
			chk(4'(seen), exp_q.size() ? 4'(exp_q.pop_front()) : 4'hf);
		end
	initial
	begin
		cyc(12);
		rst_in <= 1'b0;
		cyc(1);
		chk({internal_fast_rc_on_out, core_clk_gate_out, ext_fail_out, irq_out}, 4'hc);
		for (int d = 0; d < 4; d++)
		begin
			presc_in <= '{sys_div: 4'(d), hs_div: 3'h1, ls_div: 3'h2};
			pll_mul_in <= (d == 3) ? 4'hf : 4'($random(seed));
			cyc(20);
			{n_sys, n_hs, n_ls} = '0;
			repeat (64)
			begin
				cyc(1);
				n_sys += ticks_out.sys_en;
				n_hs += ticks_out.hs_en;
				n_ls += ticks_out.ls_en;
			end
			chk(8'(n_sys >> 1), 8'(32 >> d));
			chk(8'(n_hs), 8'(32 >> d));
			chk(8'(n_ls << 1), 8'(32 >> d));
			chk(8'(pll_mul_out), 8'((pll_mul_in > SCM_RC_PLL_MAX_MUL) ? SCM_RC_PLL_MAX_MUL : pll_mul_in));
		end
		external_fast_osc_en_in <= 1'b1;
		cyc(3);
		exp_q.push_back(SCM_SRC_EXT);
		src_req_in <= SCM_SRC_EXT;
		cyc(2);
		wait_for(0);
		exp_q.push_back(SCM_SRC_RC);
		osc_run <= 1'b0;
		wait_for(1);
		wait_for(0);
		chk({irq_out, 1'b0, src_sel_out}, 4'h8);
		fail_irq_en_in <= 1'b0;
		src_req_in <= SCM_SRC_RC;
		cyc(1);
		chk({3'h0, irq_out}, 4'h0);
		fail_clear_in <= 1'b1;
		cyc(2);
		chk({3'h0, ext_fail_out}, 4'h0);
		fail_clear_in <= 1'b0;
		pll_en_in <= 1'b1;
		deep_stop_in <= 1'b1;
		cyc(2);
		chk({internal_fast_rc_on_out, external_fast_osc_on_out, pll_on_out, core_clk_gate_out}, 4'h0);
		deep_stop_in <= 1'b0;
		cyc(3);
		chk({3'h0, internal_fast_rc_on_out}, 4'h1);
		// PLL fed by the external oscillator, then a dead crystal behind it
		pll_ref_ext_in <= 1'b1;
		pll_irq_en_in <= 1'b1;
		osc_run <= 1'b1;
		cyc(3);
		chk({3'h0, usb_clock_ok_out}, 4'h1);
		exp_q.push_back(SCM_SRC_PLL);
		src_req_in <= SCM_SRC_PLL;
		cyc(2);
		wait_for(0);
		exp_q.push_back(SCM_SRC_RC);
		osc_run <= 1'b0;
		wait_for(1);
		wait_for(0);
		chk({2'h0, irq_out, pll_on_out, usb_clock_ok_out, 1'b0, src_sel_out}, 8'h20);
		src_req_in <= SCM_SRC_RC;
		fail_clear_in <= 1'b1;
		cyc(2);
		chk({6'h0, ext_fail_out, irq_out}, 8'h00);
		fail_clear_in <= 1'b0;
		chk(4'(exp_q.size()), 4'h0);
		complete_run();
	end
endmodule
bind scm_clock_select_monitor scm_clock_select_monitor_chk chk(.*);
